// ### shared/sdcl_pkg.sv
// Shared constants for the serial converter code loader link
package sdcl_pkg;

    // Word layout
    localparam int CODE_W = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] WORD_BITS = 4'h8;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
    localparam int CODE_MSB = CODE_W - 1;

    // Pin vector positions used by the device synchroniser
    localparam int PIN_W = 4;
    localparam int PIN_SYNC = 3;
    localparam int PIN_SCLK = 2;
    localparam int PIN_DATA = 1;
    localparam int PIN_LOAD = 0;
    // Idle pin levels: frame sync high, clock low, data low, load high
    localparam logic [PIN_W-1:0] PIN_IDLE = 4'h9;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_HALF_NS = 400;
    localparam int SCLK_HALF_CYC_I =
        ((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int HALF_CNT_W = 4;
    localparam logic [HALF_CNT_W-1:0] HALF_RELOAD =
        HALF_CNT_W'(SCLK_HALF_CYC_I - 1);
    localparam logic [HALF_CNT_W-1:0] HALF_ZERO = 4'h0;

    // Device frame states
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_SHIFT = 2'b01,
        DS_FULL = 2'b10,
        DS_OVER = 2'b11
    } sdcl_dev_state_e;

    // Host frame states
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LEAD = 3'b001,
        HS_HIGH = 3'b010,
        HS_LOW = 3'b011,
        HS_POST = 3'b100,
        HS_LOAD = 3'b101,
        HS_GAP = 3'b110
    } sdcl_host_state_e;

endpackage

// ### shared/sdcl_link_if.sv
// Four-wire write link between the host end and the converter end
`timescale 1ns/1ps
interface sdcl_link_if;
    logic frame_sync_n;
    logic serial_clk;
    logic serial_data_in;
    logic load_strobe_n;

    modport host (
        output frame_sync_n,
        output serial_clk,
        output serial_data_in,
        output load_strobe_n
    );

    modport device (
        input frame_sync_n,
        input serial_clk,
        input serial_data_in,
        input load_strobe_n
    );
endinterface

// ### hdl/sdcl_device.sv
// Converter end: serial input shift register, input latch, code register
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - One frame carries one 8-bit unsigned code.
// - Frame sync edges start and end frames.
// - Shift only while frame sync is low.
// - Host lowers sync, clocks eight bits, raises.
// - Load strobe low copies word to converter.
// - Load held low updates from each word.
// - Each new word needs fresh sync falling edge.
// - Interface wakes on frame sync falling edge.
// - Sync rise sleeps clock and data inputs.
// - Sample data on serial clock falling edge.
// - With load low, update follows sync rise.
// - Word is shifted most significant bit first.
module sdcl_device
    import sdcl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial link
    sdcl_link_if.device link,
    // Converter side
    output logic [CODE_W-1:0] dac_code,
    output logic [CODE_W-1:0] input_word,
    // Status
    output logic interface_awake,
    output logic word_done,
    output logic frame_error
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser, two stages for every link input

    logic [PIN_W-1:0] pin_vec;
    logic [PIN_W-1:0] meta_reg;
    logic [PIN_W-1:0] meta_next;
    logic [PIN_W-1:0] pin_reg;
    logic [PIN_W-1:0] pin_next;

    assign pin_vec[PIN_SYNC] = link.frame_sync_n;
    assign pin_vec[PIN_SCLK] = link.serial_clk;
    assign pin_vec[PIN_DATA] = link.serial_data_in;
    assign pin_vec[PIN_LOAD] = link.load_strobe_n;

    always_comb begin
        meta_next = pin_vec;
        pin_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_reg <= PIN_IDLE;
            pin_reg <= PIN_IDLE;
        end else begin
            meta_reg <= meta_next;
            pin_reg <= pin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge finder on the synchronised levels

    logic sync_prev_reg;
    logic sync_prev_next;
    logic sclk_prev_reg;
    logic sclk_prev_next;
    logic sync_fall;
    logic sync_rise;
    logic sclk_fall;
    logic data_bit;
    logic load_low;

    always_comb begin
        sync_prev_next = pin_reg[PIN_SYNC];
        sclk_prev_next = pin_reg[PIN_SCLK];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync_prev_reg <= PIN_IDLE[PIN_SYNC];
            sclk_prev_reg <= PIN_IDLE[PIN_SCLK];
        end else begin
            sync_prev_reg <= sync_prev_next;
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    assign sync_fall = sync_prev_reg & ~pin_reg[PIN_SYNC];
    assign sync_rise = ~sync_prev_reg & pin_reg[PIN_SYNC];
    assign sclk_fall = sclk_prev_reg & ~pin_reg[PIN_SCLK];
    assign data_bit = pin_reg[PIN_DATA];
    assign load_low = ~pin_reg[PIN_LOAD];

    ////////////////////////////////////////////////////////////////////////
    // Frame state, bit counter and shift register

    sdcl_dev_state_e state_reg;
    sdcl_dev_state_e state_next;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_next;
    logic [CODE_W-1:0] shift_reg;
    logic [CODE_W-1:0] shift_next;
    logic frame_good;
    logic frame_bad;
    logic buffers_on;

    assign buffers_on = (state_reg != DS_IDLE);

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        frame_good = 1'b0;
        frame_bad = 1'b0;
        case (state_reg)
            DS_IDLE: begin
                if (sync_fall) begin
                    state_next = DS_SHIFT;
                    bit_cnt_next = '0;
                end
            end
            DS_SHIFT: begin
                if (sync_rise) begin
                    state_next = DS_IDLE;
                    frame_bad = 1'b1;
                end else if (buffers_on && sclk_fall) begin
                    shift_next = {shift_reg[CODE_MSB-1:0], data_bit};
                    bit_cnt_next = bit_cnt_reg + 1'b1;
                    if (bit_cnt_reg == LAST_BIT) begin
                        state_next = DS_FULL;
                    end
                end
            end
            DS_FULL: begin
                if (sync_rise) begin
                    state_next = DS_IDLE;
                    frame_good = 1'b1;
                end else if (buffers_on && sclk_fall) begin
                    state_next = DS_OVER;
                end
            end
            DS_OVER: begin
                // Surplus clocks leave the shifted word untouched
                if (sync_rise) begin
                    state_next = DS_IDLE;
                    frame_bad = 1'b1;
                end
            end
            default: begin
                state_next = DS_IDLE;
                bit_cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= DS_IDLE;
            bit_cnt_reg <= '0;
            shift_reg <= CODE_RESET;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input latch, converter register and status

    logic [CODE_W-1:0] latch_reg;
    logic [CODE_W-1:0] latch_next;
    logic [CODE_W-1:0] dac_reg;
    logic [CODE_W-1:0] dac_next;
    logic done_reg;
    logic done_next;
    logic err_reg;
    logic err_next;
    logic awake_reg;
    logic awake_next;

    always_comb begin
        latch_next = latch_reg;
        // Only a complete word reaches the latch; short or long frames
        // would otherwise put a shifted fragment on the output.
        if (frame_good) begin
            latch_next = shift_reg;
        end
        dac_next = load_low ? latch_reg : dac_reg;
        done_next = frame_good;
        err_next = frame_bad;
        awake_next = (state_next != DS_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            latch_reg <= CODE_RESET;
            dac_reg <= CODE_RESET;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            awake_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            dac_reg <= dac_next;
            done_reg <= done_next;
            err_reg <= err_next;
            awake_reg <= awake_next;
        end
    end

    assign dac_code = dac_reg;
    assign input_word = latch_reg;
    assign word_done = done_reg;
    assign frame_error = err_reg;
    assign interface_awake = awake_reg;

endmodule

// ### hdl/sdcl_host.sv
// Host end: frames one code per request and drives the load strobe
`timescale 1ns/1ps
module sdcl_host
    import sdcl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Request side
    input wire logic req_valid,
    input wire logic [CODE_W-1:0] req_code,
    input wire logic hold_load,
    output logic req_ready,
    // Serial link
    sdcl_link_if.host link
);

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer with half-period divider

    sdcl_host_state_e state_reg;
    sdcl_host_state_e state_next;
    logic [HALF_CNT_W-1:0] half_reg;
    logic [HALF_CNT_W-1:0] half_next;
    logic [BIT_CNT_W-1:0] bits_reg;
    logic [BIT_CNT_W-1:0] bits_next;
    logic [CODE_W-1:0] shift_reg;
    logic [CODE_W-1:0] shift_next;
    logic hold_reg;
    logic hold_next;
    logic sync_n_reg;
    logic sync_n_next;
    logic sclk_reg;
    logic sclk_next;
    logic data_reg;
    logic data_next;
    logic load_n_reg;
    logic load_n_next;
    logic tick;

    assign tick = (half_reg == HALF_ZERO);
    assign req_ready = (state_reg == HS_IDLE);

    always_comb begin
        state_next = state_reg;
        half_next = tick ? HALF_RELOAD : half_reg - 1'b1;
        bits_next = bits_reg;
        shift_next = shift_reg;
        hold_next = hold_reg;
        sync_n_next = sync_n_reg;
        sclk_next = sclk_reg;
        data_next = data_reg;
        load_n_next = load_n_reg;
        case (state_reg)
            HS_IDLE: begin
                half_next = HALF_RELOAD;
                // level follows hold request between frames
                load_n_next = ~hold_load;
                if (req_valid) begin
                    state_next = HS_LEAD;
                    shift_next = req_code;
                    hold_next = hold_load;
                    bits_next = '0;
                    sync_n_next = 1'b0;
                end
            end
            HS_LEAD: begin
                if (tick) begin
                    state_next = HS_HIGH;
                    sclk_next = 1'b1;
                    data_next = shift_reg[CODE_MSB];
                    shift_next = {shift_reg[CODE_MSB-1:0], 1'b0};
                end
            end
            HS_HIGH: begin
                if (tick) begin
                    state_next = HS_LOW;
                    sclk_next = 1'b0;
                    bits_next = bits_reg + 1'b1;
                end
            end
            HS_LOW: begin
                if (tick) begin
                    if (bits_reg == WORD_BITS) begin
                        state_next = HS_POST;
                        sync_n_next = 1'b1;
                    end else begin
                        state_next = HS_HIGH;
                        sclk_next = 1'b1;
                        data_next = shift_reg[CODE_MSB];
                        shift_next = {shift_reg[CODE_MSB-1:0], 1'b0};
                    end
                end
            end
            HS_POST: begin
                if (tick) begin
                    if (hold_reg) begin
                        state_next = HS_GAP;
                    end else begin
                        state_next = HS_LOAD;
                        load_n_next = 1'b0;
                    end
                end
            end
            HS_LOAD: begin
                if (tick) begin
                    state_next = HS_GAP;
                    load_n_next = 1'b1;
                end
            end
            HS_GAP: begin
                // sync stays high before next fall
                if (tick) begin
                    state_next = HS_IDLE;
                    data_next = 1'b0;
                end
            end
            default: begin
                state_next = HS_IDLE;
                sync_n_next = 1'b1;
                sclk_next = 1'b0;
                load_n_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= HS_IDLE;
            half_reg <= HALF_RELOAD;
            bits_reg <= '0;
            shift_reg <= CODE_RESET;
            hold_reg <= 1'b0;
            sync_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            data_reg <= 1'b0;
            load_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            half_reg <= half_next;
            bits_reg <= bits_next;
            shift_reg <= shift_next;
            hold_reg <= hold_next;
            sync_n_reg <= sync_n_next;
            sclk_reg <= sclk_next;
            data_reg <= data_next;
            load_n_reg <= load_n_next;
        end
    end

    assign link.frame_sync_n = sync_n_reg;
    assign link.serial_clk = sclk_reg;
    assign link.serial_data_in = data_reg;
    assign link.load_strobe_n = load_n_reg;

endmodule

// ### tb/sdcl_link_chk.sv
// Concurrent checks on the host-driven wires of the code link
`timescale 1ns/1ps
module sdcl_link_chk
    import sdcl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Link wires
    input wire logic frame_sync_n,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic load_strobe_n
);
    logic sclk_reg;
    logic [BIT_CNT_W-1:0] fall_reg, fall_next;
    logic [7:0] low_reg, low_next;

    ////////////////////////////////////////////////////////////////////////
    // Falls and low cycles of the open frame, cleared while sync is high
    always_comb begin
        fall_next = fall_reg;
        low_next = low_reg;
        if (frame_sync_n) begin
            fall_next = 4'h0;
            low_next = 8'h00;
        end else begin
            low_next = low_reg + 8'h01;
            if (sclk_reg && !serial_clk) begin
                fall_next = fall_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclk_reg <= 1'b0;
            fall_reg <= 4'h0;
            low_reg <= 8'h00;
        end else begin
            sclk_reg <= serial_clk;
            fall_reg <= fall_next;
            low_reg <= low_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_sclk_idle: assert property (frame_sync_n |-> !serial_clk)
        else $error("serial clock high outside a frame");
    a_data_on_rise: assert property (
        !frame_sync_n && $changed(serial_data_in) |-> $rose(serial_clk))
        else $error("data moved away from a clock rise");
    a_half_period: assert property (
        $rose(serial_clk) |-> serial_clk[*4] ##1 !serial_clk)
        else $error("serial clock high phase not four cycles");
    a_eight_falls: assert property (
        $rose(frame_sync_n) |-> fall_reg == WORD_BITS)
        else $error("frame closed without eight clock falls");
    a_frame_span: assert property (
        $rose(frame_sync_n) |-> low_reg == 8'h44)
        else $error("frame low time not 68 cycles");
    a_sync_gap: assert property (
        $rose(frame_sync_n) |-> frame_sync_n[*8])
        else $error("sync high gap shorter than eight cycles");
    a_lead_in: assert property (
        $fell(frame_sync_n) |-> (!serial_clk)[*4] ##1 serial_clk)
        else $error("first clock rise not four cycles after sync");
    a_load_idle: assert property (
        $fell(load_strobe_n) |-> frame_sync_n && $past(frame_sync_n, 4))
        else $error("load strobe fell inside or near a frame");
endmodule

// ### tb/tb_serial_dac_code_loader.sv
// Self-checking bench: host and converter joined, plus a fault link
`timescale 1ns/1ps
module tb_serial_dac_code_loader;
    import sdcl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic [CODE_W-1:0] req_code = 8'h00;
    logic hold_load = 1'b0;
    logic req_ready;
    logic [CODE_W-1:0] dac_a, word_a, dac_b, word_b, c;
    logic [CODE_W-1:0] wire_word = 8'h00;
    logic awake_a, done_a, done_b, ferr_b, ferr_a, awake_b;
    logic seen_done = 1'b0;
    logic seen_err_a = 1'b0;
    logic seen_err = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int exp_q[$];
    int model_dac = 0;
    int model_b = 0;
    int bad_len[3] = '{7, 9, 16};
    logic [CODE_W-1:0] corner[4] = '{8'h00, 8'hff, 8'h80, 8'h01};

    sdcl_link_if link_a();
    sdcl_link_if link_b();

    sdcl_host sdcl_host_i (.ref_clk(ref_clk), .reset(reset),
        .req_valid(req_valid), .req_code(req_code), .hold_load(hold_load),
        .req_ready(req_ready), .link(link_a.host));
    sdcl_device sdcl_device_i (.ref_clk(ref_clk), .reset(reset),
        .link(link_a.device), .dac_code(dac_a), .input_word(word_a),
        .interface_awake(awake_a), .word_done(done_a),
        .frame_error(ferr_a));
    // Second converter end faces the bench driver, which breaks the rules
    sdcl_device sdcl_device_2_i (.ref_clk(ref_clk), .reset(reset),
        .link(link_b.device), .dac_code(dac_b), .input_word(word_b),
        .interface_awake(awake_b), .word_done(done_b),
        .frame_error(ferr_b));
    sdcl_link_chk sdcl_link_chk_i (.ref_clk(ref_clk), .reset(reset),
        .frame_sync_n(link_a.frame_sync_n), .serial_clk(link_a.serial_clk),
        .serial_data_in(link_a.serial_data_in),
        .load_strobe_n(link_a.load_strobe_n));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Pulses are one cycle wide, so latch them for the fault scenarios
    always @(posedge ref_clk) begin
        if (done_b === 1'b1) seen_done <= 1'b1;
        if (ferr_b === 1'b1) seen_err <= 1'b1;
        if (ferr_a === 1'b1) seen_err_a <= 1'b1;
    end

    always @(negedge link_a.serial_clk) begin
        wire_word <= {wire_word[CODE_W-2:0], link_a.serial_data_in};
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [CODE_W-1:0] got,
                        input logic [CODE_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hold is set a cycle early so the strobe never moves with sync
    task automatic send(input logic [CODE_W-1:0] code, input logic hold);
        int n;
        logic [CODE_W-1:0] e;
        hold_load = hold;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_code = code;
        exp_q.push_back(code);
        @(negedge ref_clk);
        req_valid = 1'b0;
        e = CODE_W'(exp_q.pop_front());
        repeat (8) @(negedge ref_clk);
        chk1(awake_a, 1'b1);
        chk1(req_ready, 1'b0);
        n = 0;
        while (done_a !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk1(done_a, 1'b1);
        chk8(word_a, e);
        chk8(wire_word, e);
        chk8(dac_a, CODE_W'(model_dac));
        @(negedge ref_clk);
        if (hold) model_dac = e;
        chk8(dac_a, CODE_W'(model_dac));
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        model_dac = e;
        chk8(dac_a, CODE_W'(model_dac));
        chk1(awake_a, 1'b0);
        chk1(link_a.serial_clk, 1'b0);
    endtask

    // data moves with the clock rise, sampled at the fall
    task automatic shift_b(input int nbits, input logic [15:0] w);
        for (int i = nbits - 1; i >= 0; i--) begin
            link_b.serial_data_in = w[i];
            link_b.serial_clk = 1'b1;
            #400;
            link_b.serial_clk = 1'b0;
            #400;
        end
    endtask

    // sync low, bits, sync high; released data shows its inverse
    task automatic frame_b(input int nbits, input logic [15:0] w);
        seen_done = 1'b0;
        seen_err = 1'b0;
        link_b.frame_sync_n = 1'b0;
        #400;
        chk1(awake_b, 1'b1);
        shift_b(nbits, w);
        link_b.frame_sync_n = 1'b1;
        link_b.serial_data_in = ~link_b.serial_data_in;
        #1200;
        chk1(awake_b, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        link_b.frame_sync_n = 1'b1;
        link_b.serial_clk = 1'b0;
        link_b.serial_data_in = 1'b0;
        link_b.load_strobe_n = 1'b1;
        void'($urandom(47));
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk8(dac_a, CODE_RESET);
        chk8(word_a, CODE_RESET);
        chk8(dac_b, CODE_RESET);
        for (int i = 0; i < 12; i++) begin
            send(i < 4 ? corner[i] : CODE_W'($urandom), i[1]);
        end
        // Fault link steps in whole cycles, so it moves on falling edges
        c = CODE_W'($urandom);
        frame_b(8, {8'h00, c});
        chk1(seen_done, 1'b1);
        chk8(word_b, c);
        chk8(dac_b, CODE_W'(model_b));
        link_b.load_strobe_n = 1'b0;
        #800;
        link_b.load_strobe_n = 1'b1;
        #400;
        model_b = c;
        chk8(dac_b, CODE_W'(model_b));
        foreach (bad_len[k]) begin
            frame_b(bad_len[k], 16'ha5c3);
            chk1(seen_err, 1'b1);
            chk8(word_b, CODE_W'(model_b));
        end
        seen_done = 1'b0;
        shift_b(8, 16'h005a);
        #800;
        chk1(seen_done, 1'b0);
        chk1(awake_b, 1'b0);
        chk8(word_b, CODE_W'(model_b));
        link_b.load_strobe_n = 1'b0;
        c = CODE_W'($urandom);
        link_b.frame_sync_n = 1'b0;
        #400;
        shift_b(8, {8'h00, c});
        chk8(dac_b, CODE_W'(model_b));
        link_b.frame_sync_n = 1'b1;
        #1200;
        model_b = c;
        chk8(dac_b, CODE_W'(model_b));
        chk1(seen_err_a, 1'b0);
        test_done;
    end

    // Whole run is near 153 us; a hang is cut at 5 ms
    initial begin
        #5000000;
        err_count++;
        test_done;
    end
endmodule
